/* hdl/bao_btn.v */
`timescale 1ns/1ns
`default_nettype none
`include "bao_regs.vh"
module bao_btn #(
   parameter [19:0] DEBOUNCE_CYC = `BAO_DEBOUNCE_CYC,
   parameter [26:0] LONG_CYC = `BAO_LONG_CYC
) (
   input wire pclk, // block clock
   input wire presetn, // async reset, active low
   input wire button_n, // raw button pin, low while pressed
   output reg short_evt_q, // one-cycle pulse on a short release
   output reg long_evt_q, // one-cycle pulse when hold time is reached
   output reg pressed_q // debounced pressed level
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_HELD = 3'b010;
   localparam [2:0] ST_WAIT = 3'b100;
   wire raw_pressed;
   reg [19:0] deb_q;
   reg [26:0] hold_q;
   reg [2:0] st_q;

   bao_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(~button_n),
      .rst_val(1'b0),
      .dout(raw_pressed)
   );

   // ----------------------------------------------------------------
   // debounce: level must stay different for the whole window
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deb_q <= 20'h00000;
         pressed_q <= 1'b0;
      end else if (raw_pressed == pressed_q) begin
         deb_q <= 20'h00000;
      end else if (deb_q >= DEBOUNCE_CYC - 20'h00001) begin
         deb_q <= 20'h00000;
         pressed_q <= raw_pressed;
      end else begin
         deb_q <= deb_q + 20'h00001;
      end
   end

   // press classification; a long press fires once and eats its release
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         hold_q <= 27'h0000000;
         short_evt_q <= 1'b0;
         long_evt_q <= 1'b0;
      end else begin
         short_evt_q <= 1'b0;
         long_evt_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               hold_q <= 27'h0000000;
               if (pressed_q) begin
                  st_q <= ST_HELD;
               end
            end
            ST_HELD: begin
               hold_q <= hold_q + 27'h0000001;
               if (!pressed_q) begin
                  short_evt_q <= 1'b1;
                  st_q <= ST_IDLE;
               end else if (hold_q >= LONG_CYC - 27'h0000001) begin
                  long_evt_q <= 1'b1;
                  st_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!pressed_q) begin
                  st_q <= ST_IDLE;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // bao_btn
`default_nettype wire

/* hdl/bao_regs.vh */
`ifndef BAO_REGS_VH
`define BAO_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define BAO_IDX_LIVE 12'h340
`define BAO_IDX_MODE 12'h342
`define BAO_IDX_MANUAL 12'h343
`define BAO_IDX_SAVED 12'h344
`define BAO_IDX_SHORT 12'h700
`define BAO_IDX_LONG 12'h701
`define BAO_IDX_ZERO 12'h7F0
`define BAO_IDX_STATUS 12'h7F1

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define BAO_SHORT_RST 3'h1
`define BAO_LONG_RST 3'h0
`define BAO_MODE_RST 1'h1
`define BAO_SAVED_RST 1'h0
`define BAO_ACT_NONE 3'h0
`define BAO_ACT_ADV 3'h1
`define BAO_ACT_RESET 3'h2
`define BAO_ACT_MEAS 3'h3
`define BAO_ACT_ALARM 3'h4
`define BAO_ACT_TARE 3'h5
`define BAO_ACT_MAX 3'h5
`define BAO_SAVE_SHORT 2'h0
`define BAO_SAVE_LONG 2'h1
`define BAO_SAVE_MODE 2'h2
`define BAO_SAVE_LEVEL 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
// sized to the counters: 20 ms and 2 s at the 50 MHz block clock
`define BAO_DEBOUNCE_CYC 20'hF4240
`define BAO_LONG_CYC 27'h5F5E100

`endif

/* hdl/bao_sync.v */
`timescale 1ns/1ns
`default_nettype none
module bao_sync (
   input wire pclk, // block clock
   input wire presetn, // async reset, active low
   input wire din, // asynchronous level
   input wire rst_val, // level assumed during reset, must be constant
   output wire dout // synchronised level
);
   reg meta_q;
   reg sync_q;

   // ----------------------------------------------------------------
   // two-flop synchroniser, first stage read only by the second
   // ----------------------------------------------------------------
   // the flops hold din flipped against ~rst_val, so their constant reset
   // of one reads back as rst_val and no false edge follows reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= din ^ ~rst_val;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q ^ ~rst_val; // rst_val is tied, so no path from meta_q
endmodule // bao_sync
`default_nettype wire

/* hdl/bao_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "bao_regs.vh"
module bao_top #(
   parameter [19:0] DEBOUNCE_CYC = `BAO_DEBOUNCE_CYC,
   parameter [26:0] LONG_CYC = `BAO_LONG_CYC
) (
   input wire pclk, // block clock, 50 MHz
   input wire presetn, // async reset, active low
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb direction, high for write
   input wire [15:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output wire pready, // apb ready, never stretched
   output reg [31:0] prdata, // apb read data, registered in setup
   output wire pslverr, // apb error on unmapped address
   input wire button_n, // push button pin, low while pressed
   input wire safety_close, // safety-feature request to close switch
   output wire switch_o, // open-collector output value, always low
   output wire switch_oe, // high while the switch pulls to ground
   output reg act_advertise_q, // pulse: start wireless advertising
   output reg act_dev_reset_q, // pulse: request device reset
   output reg act_meas_toggle_q, // pulse: toggle measurement on or off
   output reg act_alarm_clear_q, // pulse: clear alarms
   output reg act_tare_q, // pulse: set zero-pressure reference
   output reg nvm_save_valid_q, // persistent save request pending
   output reg [1:0] nvm_save_sel_q, // which item is being saved
   output reg [15:0] nvm_save_data_q, // value to save
   input wire nvm_save_ready // store accepts the request
);

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // true when a byte address hits a register index
   function hit;
      input [15:0] addr;
      input [11:0] idx;
      begin
         hit = (addr == {2'h0, idx, 2'h0});
      end
   endfunction

   // action index to one-hot request vector {tare,alarm,meas,reset,adv}
   function [4:0] decode_act;
      input [2:0] idx;
      begin
         case (idx)
            `BAO_ACT_ADV: decode_act = 5'h01;
            `BAO_ACT_RESET: decode_act = 5'h02;
            `BAO_ACT_MEAS: decode_act = 5'h04;
            `BAO_ACT_ALARM: decode_act = 5'h08;
            `BAO_ACT_TARE: decode_act = 5'h10;
            default: decode_act = 5'h00;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   reg [2:0] short_q;
   reg [2:0] long_q;
   reg mode_q;
   reg manual_q;
   reg saved_q;
   reg init_q;
   reg switch_q;
   reg err_q;
   reg [3:0] pend_q;
   reg [3:0] pend_set;
   reg [4:0] act_d;
   reg [31:0] rdata_d;
   reg err_d;
   reg [1:0] pick;
   reg [15:0] pick_data;
   wire short_evt;
   wire long_evt;
   wire pressed;
   wire setup_ph;
   wire wr_acc;
   wire [15:0] wval;
   wire wnz;
   wire zero_wr;
   wire switch_d;

   // ----------------------------------------------------------------
   // button front end
   // ----------------------------------------------------------------
   bao_btn #(
      .DEBOUNCE_CYC(DEBOUNCE_CYC),
      .LONG_CYC(LONG_CYC)
   ) u_btn (
      .pclk(pclk),
      .presetn(presetn),
      .button_n(button_n),
      .short_evt_q(short_evt),
      .long_evt_q(long_evt),
      .pressed_q(pressed)
   );

   // ----------------------------------------------------------------
   // apb handshake
   // ----------------------------------------------------------------

   // zero wait states: read data and error are captured in setup
   assign pready = 1'b1;
   assign pslverr = psel & penable & err_q;
   assign setup_ph = psel & ~penable;
   assign wr_acc = psel & penable & pwrite & ~err_q;
   assign wval = pwdata[15:0];
   assign wnz = |wval;
   assign zero_wr = wr_acc & hit(paddr, `BAO_IDX_ZERO);

   // read mux and address check
   always @* begin
      rdata_d = 32'h00000000;
      err_d = 1'b0;
      if (hit(paddr, `BAO_IDX_LIVE)) begin
         rdata_d[0] = switch_q;
      end else if (hit(paddr, `BAO_IDX_MODE)) begin
         rdata_d[0] = mode_q;
      end else if (hit(paddr, `BAO_IDX_MANUAL)) begin
         rdata_d[0] = manual_q;
      end else if (hit(paddr, `BAO_IDX_SAVED)) begin
         rdata_d[0] = saved_q;
      end else if (hit(paddr, `BAO_IDX_SHORT)) begin
         rdata_d[2:0] = short_q;
      end else if (hit(paddr, `BAO_IDX_LONG)) begin
         rdata_d[2:0] = long_q;
      end else if (hit(paddr, `BAO_IDX_ZERO)) begin
         rdata_d = 32'h00000000;
      end else if (hit(paddr, `BAO_IDX_STATUS)) begin
         rdata_d[3:0] = {nvm_save_valid_q | (|pend_q), init_q, mode_q, pressed};
      end else begin
         err_d = 1'b1;
      end
   end

   // capture at the setup edge so prdata comes from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         err_q <= 1'b0;
      end else if (setup_ph) begin
         prdata <= pwrite ? 32'h00000000 : rdata_d;
         err_q <= err_d;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------

   // action indices above the top code are dropped so the decode stays defined
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         short_q <= `BAO_SHORT_RST;
         long_q <= `BAO_LONG_RST;
      end else if (wr_acc && wval <= {13'h0000, `BAO_ACT_MAX}) begin
         if (hit(paddr, `BAO_IDX_SHORT)) begin
            short_q <= wval[2:0];
         end
         if (hit(paddr, `BAO_IDX_LONG)) begin
            long_q <= wval[2:0];
         end
      end
   end

   // control mode: only 0 and 1 are accepted
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= `BAO_MODE_RST;
      end else if (wr_acc && hit(paddr, `BAO_IDX_MODE) && wval[15:1] == 15'h0000) begin
         mode_q <= wval[0];
      end
   end

   // persistent default level, never touched by manual writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         saved_q <= `BAO_SAVED_RST;
      end else if (wr_acc && hit(paddr, `BAO_IDX_SAVED)) begin
         saved_q <= wnz;
      end
   end

   // manual level: loaded from the default once after reset, then written
   // by software; a write in mode 0 is an attempt to control and is dropped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_q <= 1'b0;
         manual_q <= 1'b0;
      end else if (!init_q) begin
         init_q <= 1'b1;
         manual_q <= saved_q;
      end else if (wr_acc && hit(paddr, `BAO_IDX_MANUAL) && mode_q) begin
         manual_q <= wnz;
      end
   end

   // ----------------------------------------------------------------
   // open-collector switch
   // ----------------------------------------------------------------

   // held open until the manual level has been loaded from the default
   assign switch_d = init_q & mode_q & (manual_q | safety_close);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_q <= 1'b0;
      end else begin
         switch_q <= switch_d;
      end
   end

   // the pin only ever sinks; enable high means closed to ground
   assign switch_o = 1'b0;
   assign switch_oe = switch_q;

   // ----------------------------------------------------------------
   // button actions
   // ----------------------------------------------------------------

   // short and long events never coincide, so their decodes simply merge
   always @* begin
      act_d = 5'h00;
      if (short_evt) begin
         act_d = decode_act(short_q);
      end
      if (long_evt) begin
         act_d = act_d | decode_act(long_q);
      end
   end

   // one-cycle request pulses; tare shares its pulse with the command write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_advertise_q <= 1'b0;
         act_dev_reset_q <= 1'b0;
         act_meas_toggle_q <= 1'b0;
         act_alarm_clear_q <= 1'b0;
         act_tare_q <= 1'b0;
      end else begin
         act_advertise_q <= act_d[0];
         act_dev_reset_q <= act_d[1];
         act_meas_toggle_q <= act_d[2];
         act_alarm_clear_q <= act_d[3];
         act_tare_q <= act_d[4] | zero_wr;
      end
   end

   // ----------------------------------------------------------------
   // persistent save queue
   // ----------------------------------------------------------------

   // which items a write in this cycle marks for saving
   always @* begin
      pend_set = 4'h0;
      if (wr_acc && wval <= {13'h0000, `BAO_ACT_MAX}) begin
         pend_set[`BAO_SAVE_SHORT] = hit(paddr, `BAO_IDX_SHORT);
         pend_set[`BAO_SAVE_LONG] = hit(paddr, `BAO_IDX_LONG);
      end
      if (wr_acc && wval[15:1] == 15'h0000) begin
         pend_set[`BAO_SAVE_MODE] = hit(paddr, `BAO_IDX_MODE);
      end
      if (wr_acc) begin
         pend_set[`BAO_SAVE_LEVEL] = hit(paddr, `BAO_IDX_SAVED);
      end
   end

   // lowest pending item goes first; its value is sampled when picked
   always @* begin
      pick = `BAO_SAVE_LEVEL;
      if (pend_q[0]) begin
         pick = `BAO_SAVE_SHORT;
      end else if (pend_q[1]) begin
         pick = `BAO_SAVE_LONG;
      end else if (pend_q[2]) begin
         pick = `BAO_SAVE_MODE;
      end
      case (pick)
         `BAO_SAVE_SHORT: pick_data = {13'h0000, short_q};
         `BAO_SAVE_LONG: pick_data = {13'h0000, long_q};
         `BAO_SAVE_MODE: pick_data = {15'h0000, mode_q};
         default: pick_data = {15'h0000, saved_q};
      endcase
   end

   // a write landing in the pick cycle keeps its bit set, so the newer
   // value is saved again afterwards rather than lost
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 4'h0;
         nvm_save_valid_q <= 1'b0;
         nvm_save_sel_q <= 2'h0;
         nvm_save_data_q <= 16'h0000;
      end else begin
         if (nvm_save_valid_q && nvm_save_ready) begin
            nvm_save_valid_q <= 1'b0;
         end else if (!nvm_save_valid_q && (|pend_q)) begin
            nvm_save_valid_q <= 1'b1;
            nvm_save_sel_q <= pick;
            nvm_save_data_q <= pick_data;
         end
         pend_q <= ((!nvm_save_valid_q && (|pend_q)) ? (pend_q & ~(4'h1 << pick)) : pend_q) | pend_set;
      end
   end

endmodule // bao_top
`default_nettype wire

/* tb/bao_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bao_regs.vh"
module bao_props #(
   parameter [19:0] DEBOUNCE_CYC = 20'h4,
   parameter [26:0] LONG_CYC = 27'h28
) (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [15:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic pready, // apb ready
   input wire logic [31:0] prdata, // apb read data
   input wire logic pslverr, // apb error
   input wire logic safety_close, // safety request
   input wire logic switch_o, // switch value
   input wire logic switch_oe, // switch closed
   input wire logic act_advertise_q, // action pulse
   input wire logic act_dev_reset_q, // action pulse
   input wire logic act_meas_toggle_q, // action pulse
   input wire logic act_alarm_clear_q, // action pulse
   input wire logic act_tare_q, // action pulse
   input wire logic nvm_save_valid_q, // save request
   input wire logic [1:0] nvm_save_sel_q, // save item
   input wire logic [15:0] nvm_save_data_q, // save value
   input wire logic nvm_save_ready // store ready
);
   localparam [15:0] A_LIVE = {2'b00, `BAO_IDX_LIVE, 2'b00};
   localparam [15:0] A_MODE = {2'b00, `BAO_IDX_MODE, 2'b00};
   localparam [15:0] A_MAN = {2'b00, `BAO_IDX_MANUAL, 2'b00};
   localparam [15:0] A_ZERO = {2'b00, `BAO_IDX_ZERO, 2'b00};
   logic wr, rd, mode_q, man_q;
   logic [1:0] up_q;
   assign wr = psel & penable & pwrite & pready;
   assign rd = psel & penable & ~pwrite;
   // shadow of mode and level built from bus writes only, so a stuck design register shows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 1'b1;
         man_q <= 1'b0;
         up_q <= 2'h0;
      end else begin
         if (up_q != 2'h2) up_q <= up_q + 2'h1;
         if (wr && paddr == A_MODE && pwdata[15:1] == 15'h0) mode_q <= pwdata[0];
         if (wr && paddr == A_MAN && mode_q) man_q <= |pwdata[15:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_switch_follow: assert property (up_q == 2'h2 |-> switch_oe == $past(mode_q & (man_q | safety_close)))
      else $error("switch does not follow mode and level");
   a_mode_off_float: assert property (!mode_q |=> !switch_oe)
      else $error("switch closed in off mode");
   a_oc_low: assert property (switch_o == 1'b0)
      else $error("switch output value not low");
   a_live_read: assert property (rd && paddr == A_LIVE |-> prdata == {31'h0, $past(switch_oe)})
      else $error("live state read wrong");
   a_mode_read: assert property (rd && paddr == A_MODE |-> prdata == {31'h0, $past(mode_q)})
      else $error("mode read wrong");
   a_level_read: assert property (rd && paddr == A_MAN |-> prdata == {31'h0, $past(man_q)})
      else $error("manual level read wrong");
   a_tare_cmd: assert property (wr && paddr == A_ZERO |=> act_tare_q)
      else $error("zero command gave no tare");
   a_act_single: assert property ($onehot0({act_advertise_q, act_dev_reset_q, act_meas_toggle_q,
      act_alarm_clear_q, act_tare_q}))
      else $error("two actions at once");
   a_tare_pulse: assert property (act_tare_q |=> !act_tare_q)
      else $error("tare pulse too long");
   a_save_hold: assert property (nvm_save_valid_q && !nvm_save_ready |=>
      nvm_save_valid_q && $stable(nvm_save_sel_q) && $stable(nvm_save_data_q))
      else $error("save request dropped or changed");
endmodule // bao_props
bind bao_top bao_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .LONG_CYC(LONG_CYC)) u_props (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .safety_close, .switch_o, .switch_oe,
   .act_advertise_q, .act_dev_reset_q, .act_meas_toggle_q, .act_alarm_clear_q, .act_tare_q,
   .nvm_save_valid_q, .nvm_save_sel_q, .nvm_save_data_q, .nvm_save_ready);
`default_nettype wire

/* tb/bao_tb_panel.sv */
`timescale 1ns/1ns
`default_nettype none
module bao_tb_panel (
   input wire logic pclk, // clock
   input wire logic switch_o, // switch value
   input wire logic switch_oe, // switch closed
   output logic button_n, // button pin, pulled up
   output wire logic load_level // load side of the switch
);
   // the load hangs on a pull-up, so a floating switch reads high
   assign load_level = switch_oe ? switch_o : 1'b1;
   initial button_n = 1'b1;
   // one-cycle contact bounce first, shorter than the debounce window
   task automatic press(input int hold);
      @(posedge pclk) button_n <= 1'b0;
      @(posedge pclk) button_n <= 1'b1;
      @(posedge pclk) button_n <= 1'b0;
      repeat (hold) @(posedge pclk);
      button_n <= 1'b1;
   endtask
endmodule // bao_tb_panel
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bao_regs.vh"
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, safety_close = 0, nvm_save_ready = 1, err;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0, rd;
   logic [1:0] last_sel;
   logic [15:0] last_data;
   wire pready, pslverr, switch_o, switch_oe, button_n, load_level, nvm_save_valid_q;
   wire [31:0] prdata;
   wire [1:0] nvm_save_sel_q;
   wire [15:0] nvm_save_data_q;
   wire [4:0] acts;
   int failures = 0, num_checks = 0, save_cnt = 0, act_cnt[5], n0;
   always #10 pclk = ~pclk;
   bao_top #(.DEBOUNCE_CYC(20'h4), .LONG_CYC(27'h28)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .button_n, .safety_close, .switch_o, .switch_oe,
      .act_advertise_q(acts[0]), .act_dev_reset_q(acts[1]), .act_meas_toggle_q(acts[2]),
      .act_alarm_clear_q(acts[3]), .act_tare_q(acts[4]), .nvm_save_valid_q, .nvm_save_sel_q,
      .nvm_save_data_q, .nvm_save_ready);
   bao_tb_panel u_panel (.pclk, .switch_o, .switch_oe, .button_n, .load_level);
   // ----------------------------------------
   // monitors and tasks
   // ----------------------------------------
   // count action pulses and finished saves
   always @(posedge pclk) begin
      for (int i = 0; i < 5; i++)
         if (acts[i] === 1'b1) act_cnt[i]++;
      if (nvm_save_valid_q === 1'b1 && nvm_save_ready) begin
         save_cnt++;
         last_sel = nvm_save_sel_q;
         last_data = nvm_save_data_q;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; the word index times four is the byte address
   task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      chk({31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp);
      chk({31'h0, err}, 32'h0);
   endtask
   // waits a bounded time for the next save, then checks item and value
   task automatic svchk(input logic [1:0] s, input logic [15:0] d);
      int n;
      n = 0;
      while (save_cnt == n0 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(save_cnt - n0), 32'h1);
      chk({14'h0, last_sel, last_data}, {14'h0, s, d});
      n0 = save_cnt;
   endtask
   // a press of the given hold, then exactly the expected action pulse (0 for none)
   task automatic act(input int hold, input int a);
      int c[5];
      c = act_cnt;
      u_panel.press(hold);
      repeat (20) @(posedge pclk);
      for (int i = 0; i < 5; i++) chk(32'(act_cnt[i] - c[i]), 32'(a == i + 1));
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      $display("ERROR %0t: timeout", $time);
      tally_and_finish;
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`BAO_IDX_LIVE, 32'h0);
      rdchk(`BAO_IDX_MODE, 32'h1);
      rdchk(`BAO_IDX_MANUAL, 32'h0);
      rdchk(`BAO_IDX_SAVED, 32'h0);
      rdchk(`BAO_IDX_SHORT, 32'h1);
      rdchk(`BAO_IDX_LONG, 32'h0);
      apb(1'b0, 12'h345, 32'h0);
      chk({31'h0, err}, 32'h1);
      n0 = save_cnt;
      // every action code: stored, saved, then fired by a short press
      for (int a = 0; a <= 5; a++) begin
         apb(1'b1, `BAO_IDX_SHORT, 32'(a));
         svchk(2'h0, 16'(a));
         act(15, a);
      end
      apb(1'b1, `BAO_IDX_SHORT, 32'h6);
      rdchk(`BAO_IDX_SHORT, 32'h5);
      // long press uses its own code, the release adds nothing
      apb(1'b1, `BAO_IDX_LONG, 32'h3);
      svchk(2'h1, 16'h3);
      act(60, 3);
      apb(1'b1, `BAO_IDX_ZERO, 32'h0);
      repeat (2) @(posedge pclk);
      chk(32'(act_cnt[4]), 32'h2);
      // bad mode dropped, manual level normalised and never saved
      apb(1'b1, `BAO_IDX_MODE, 32'h2);
      rdchk(`BAO_IDX_MODE, 32'h1);
      apb(1'b1, `BAO_IDX_MANUAL, 32'h700);
      rdchk(`BAO_IDX_MANUAL, 32'h1);
      rdchk(`BAO_IDX_LIVE, 32'h1);
      chk({31'h0, load_level}, 32'h0);
      chk(32'(save_cnt - n0), 32'h0);
      // store stalls while the off mode is saved
      nvm_save_ready <= 1'b0;
      apb(1'b1, `BAO_IDX_MODE, 32'h0);
      repeat (4) @(posedge pclk);
      chk({29'h0, nvm_save_valid_q, nvm_save_sel_q}, 32'h6);
      nvm_save_ready <= 1'b1;
      svchk(2'h2, 16'h0);
      rdchk(`BAO_IDX_LIVE, 32'h0);
      chk({31'h0, load_level}, 32'h1);
      safety_close <= 1'b1;
      apb(1'b1, `BAO_IDX_MANUAL, 32'h0);
      rdchk(`BAO_IDX_MANUAL, 32'h1);
      rdchk(`BAO_IDX_LIVE, 32'h0);
      apb(1'b1, `BAO_IDX_MODE, 32'h1);
      svchk(2'h2, 16'h1);
      apb(1'b1, `BAO_IDX_MANUAL, 32'h0);
      rdchk(`BAO_IDX_MANUAL, 32'h0);
      rdchk(`BAO_IDX_LIVE, 32'h1);
      safety_close <= 1'b0;
      apb(1'b1, `BAO_IDX_SAVED, 32'h2);
      svchk(2'h3, 16'h1);
      rdchk(`BAO_IDX_SAVED, 32'h1);
      rdchk(`BAO_IDX_MANUAL, 32'h0);
      rdchk(`BAO_IDX_LIVE, 32'h0);
      // second reset: the default register resets to 0, so the level reloads as 0
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`BAO_IDX_MANUAL, 32'h0);
      rdchk(`BAO_IDX_LIVE, 32'h0);
      rdchk(`BAO_IDX_STATUS, 32'h6);
      tally_and_finish;
   end
endmodule // tb
`default_nettype wire
